// File: src/mme_pkg.sv
// package for the monitor mode entry control block
// assumes a 40 MHz system clock on aclk and 32-bit AXI4-Lite register access
package mme_pkg;
  // register byte offsets
  localparam logic [7:0] MME_OFF_CTRL = 8'h00;
  localparam logic [7:0] MME_OFF_STATUS = 8'h04;
  localparam logic [7:0] MME_OFF_RST_VEC = 8'h08;
  localparam logic [7:0] MME_OFF_SEC_LO = 8'h0C;
  localparam logic [7:0] MME_OFF_SEC_HI = 8'h10;
  localparam logic [7:0] MME_OFF_BAUD = 8'h14;
  // vector addresses
  localparam logic [15:0] MME_VEC_RST_USER = 16'hFFFE;
  localparam logic [15:0] MME_VEC_RST_MON = 16'hFEFE;
  localparam logic [15:0] MME_VEC_SWI_USER = 16'hFFFC;
  localparam logic [15:0] MME_VEC_SWI_MON = 16'hFEFC;
  localparam logic [15:0] MME_SEC_BASE = 16'hFFF6;
  localparam logic [7:0] MME_ERASED = 8'hFF;
  // serial timing
  localparam int MME_BAUD_DIV = 278;
  localparam int MME_BREAK_BITS = 10;
  localparam int MME_SEC_BYTES = 8;
  localparam logic [15:0] MME_BAUD_RESET = 16'h0116;
  // clock divider encodings
  localparam logic [1:0] MME_DIV_BY2 = 2'h1;
  localparam logic [1:0] MME_DIV_BY4 = 2'h2;
  localparam logic [1:0] MME_DIV_USER = 2'h0;

  typedef enum logic [1:0] {
    MME_MODE_USER = 2'b00,
    MME_MODE_NORMAL = 2'b01,
    MME_MODE_FORCED = 2'b10
  } mme_mode_t;

  typedef enum logic [2:0] {
    MME_ST_POR = 3'b000,
    MME_ST_EXTRA_RST = 3'b001,
    MME_ST_SEC = 3'b010,
    MME_ST_BREAK = 3'b011,
    MME_ST_READY = 3'b100,
    MME_ST_USER = 3'b101
  } mme_state_t;
endpackage : mme_pkg

// File: src/mme_bit_if.sv
// bit timer carrier between the entry control and its bit timer
// assumes a single clock domain
`timescale 1ns/1ps
interface mme_bit_if;
  logic start;
  logic [15:0] period;
  logic tick;
  modport ctrl (output start, output period, input tick);
  modport timer (input start, input period, output tick);
endinterface : mme_bit_if

// File: src/mme_bit_timer.sv
// bit timer: pulses tick once per period of bus-clock cycles
// assumes period of at least two
`timescale 1ns/1ps
module mme_bit_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // carrier
  mme_bit_if.timer bt
);
  logic [WIDTH-1:0] count;
  wire logic at_end = (count == bt.period - 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn || bt.start) begin
      count <= '0;
    end else if (at_end) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end

  assign bt.tick = at_end && !bt.start;
endmodule : mme_bit_timer

// File: src/mme_entry.sv
// monitor mode entry control: mode latch, clock divider choice, watchdog gate,
// vector relocation, security byte wait and ready break on the comm pin
// assumes pins synchronous to aclk; the serial receiver delivers bytes as strobes
// How it works
// - monitor mode is entered only after power-on reset or with soft_reenter set
// - mode is latched on reset pin rising edge; later pin changes ignored
// - entry without test voltage ignores all port B pins including divider select
// - forced entry needs erased reset vector; bus runs at clock divided by four
// - normal entry, divider select low: bus is clock over two, bypass stage
// - normal entry, divider select high: bus is clock over four
// - normal entry: watchdog off while test voltage on interrupt or reset pin
// - forced entry keeps watchdog off always
// - forced entry performs one extra reset cycle after power-on
// - monitor vectors sit in the FE page, user vectors in FF page
// - wait for eight security bytes, then send ten zero bits
// - comm pin is wired-OR, both sides only pull low
// - one serial bit lasts 278 bus cycles
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module mme_entry
  import mme_pkg::*;
#(
  parameter int BAUD_DIV = MME_BAUD_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset pin and power-on reset
  input wire logic por_event,
  input wire logic reset_pin,
  input wire logic reset_pin_high_voltage,
  // mode selection pins
  input wire logic irq_high_voltage,
  input wire logic monitor_comm_pin_in,
  input wire logic serial_select_pin,
  input wire logic mode_select_pin_0,
  input wire logic mode_select_pin_1,
  input wire logic divider_select_pin,
  // received security bytes
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  // comm pin drive
  output logic monitor_comm_pin_out,
  output logic monitor_comm_pin_oe,
  // clocking and system outputs
  output logic [1:0] bus_divider,
  output logic osc_bypass_div2,
  output logic synth_enable,
  output logic watchdog_disable,
  output logic monitor_active,
  output logic extra_reset,
  output logic security_ok,
  output logic monitor_ready,
  output logic [15:0] reset_vector_addr,
  output logic [15:0] swi_vector_addr,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  mme_bit_if bt ();

  // registers
  logic [15:0] rst_vec;
  logic [31:0] sec_lo;
  logic [31:0] sec_hi;
  logic [15:0] baud_period;
  logic soft_reenter;
  mme_mode_t mode;
  mme_state_t state;
  logic reset_pin_q;
  logic por_seen;
  logic [3:0] byte_cnt;
  logic [3:0] bit_cnt;
  logic sec_match;
  logic div4_latched;

  // mode decode from pins
  wire logic vector_blank = (rst_vec[15:8] == MME_ERASED) && (rst_vec[7:0] == MME_ERASED);
  wire logic normal_pins = irq_high_voltage && monitor_comm_pin_in && !serial_select_pin
    && mode_select_pin_0 && !mode_select_pin_1;
  // port B ignored here on purpose
  wire logic forced_pins = !irq_high_voltage && vector_blank && monitor_comm_pin_in
    && !serial_select_pin;
  wire mme_mode_t pin_mode = normal_pins ? MME_MODE_NORMAL :
    (forced_pins ? MME_MODE_FORCED : MME_MODE_USER);
  wire logic reset_rise = reset_pin && !reset_pin_q;
  wire logic [2:0] sec_idx = byte_cnt[2:0];
  wire logic [63:0] sec_all = {sec_hi, sec_lo};
  wire logic [7:0] sec_expect = sec_all[{sec_idx, 3'h0} +: 8];

  // latch mode on the reset pin rising edge, only after power-on reset or with soft_reenter set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_pin_q <= 1'b1;
      por_seen <= 1'b0;
      mode <= MME_MODE_USER;
      div4_latched <= 1'b0;
    end else begin
      reset_pin_q <= reset_pin;
      if (por_event) begin
        por_seen <= 1'b1;
      end else if (reset_rise) begin
        por_seen <= 1'b0;
      end
      if (reset_rise && (por_seen || soft_reenter)) begin
        mode <= pin_mode;
        div4_latched <= divider_select_pin;
      end
    end
  end

  // entry sequence
  assign bt.period = baud_period;
  assign bt.start = (state == MME_ST_SEC && byte_cnt == 4'(MME_SEC_BYTES - 1) && rx_byte_valid);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= MME_ST_POR;
      byte_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      sec_match <= 1'b1;
      security_ok <= 1'b0;
      extra_reset <= 1'b0;
    end else begin
      extra_reset <= 1'b0;
      unique case (state)
        MME_ST_POR: begin
          if (reset_rise && (por_seen || soft_reenter)) begin
            byte_cnt <= 4'h0;
            sec_match <= 1'b1;
            if (pin_mode == MME_MODE_FORCED) begin
              state <= MME_ST_EXTRA_RST;
            end else if (pin_mode == MME_MODE_NORMAL) begin
              state <= MME_ST_SEC;
            end else begin
              state <= MME_ST_USER;
            end
          end
        end
        MME_ST_EXTRA_RST: begin
          extra_reset <= 1'b1;
          state <= MME_ST_SEC;
        end
        MME_ST_SEC: begin
          if (rx_byte_valid) begin
            if (rx_byte != sec_expect) begin
              sec_match <= 1'b0;
            end
            byte_cnt <= byte_cnt + 4'h1;
            if (byte_cnt == 4'(MME_SEC_BYTES - 1)) begin
              security_ok <= sec_match && (rx_byte == sec_expect);
              bit_cnt <= 4'h0;
              state <= MME_ST_BREAK;
            end
          end
        end
        MME_ST_BREAK: begin
          if (bt.tick) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'(MME_BREAK_BITS - 1)) begin
              state <= MME_ST_READY;
            end
          end
        end
        MME_ST_READY: begin
          if (reset_rise && soft_reenter) begin
            state <= MME_ST_POR;
          end
        end
        MME_ST_USER: begin
          if (reset_rise && (por_seen || soft_reenter)) begin
            state <= MME_ST_POR;
          end
        end
      endcase
    end
  end

  // outputs from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_comm_pin_out <= 1'b0;
      monitor_comm_pin_oe <= 1'b0;
      bus_divider <= MME_DIV_USER;
      osc_bypass_div2 <= 1'b0;
      synth_enable <= 1'b0;
      watchdog_disable <= 1'b0;
      monitor_active <= 1'b0;
      monitor_ready <= 1'b0;
      reset_vector_addr <= MME_VEC_RST_USER;
      swi_vector_addr <= MME_VEC_SWI_USER;
    end else begin
      // wired-OR: only ever pull low, release otherwise
      monitor_comm_pin_out <= 1'b0;
      monitor_comm_pin_oe <= (state == MME_ST_BREAK);
      monitor_active <= (mode != MME_MODE_USER);
      monitor_ready <= (state == MME_ST_READY);
      unique case (mode)
        MME_MODE_NORMAL: begin
          bus_divider <= div4_latched ? MME_DIV_BY4 : MME_DIV_BY2;
          osc_bypass_div2 <= !div4_latched;
          synth_enable <= 1'b0;
          watchdog_disable <= irq_high_voltage || reset_pin_high_voltage;
        end
        MME_MODE_FORCED: begin
          bus_divider <= MME_DIV_BY4;
          osc_bypass_div2 <= 1'b0;
          synth_enable <= 1'b0;
          watchdog_disable <= 1'b1;
        end
        default: begin
          bus_divider <= MME_DIV_USER;
          osc_bypass_div2 <= 1'b0;
          synth_enable <= 1'b1;
          watchdog_disable <= 1'b0;
        end
      endcase
      // monitor vectors in the FE page
      reset_vector_addr <= (mode != MME_MODE_USER) ? MME_VEC_RST_MON : MME_VEC_RST_USER;
      swi_vector_addr <= (mode != MME_MODE_USER) ? MME_VEC_SWI_MON : MME_VEC_SWI_USER;
    end
  end

  mme_bit_timer #(
    .WIDTH(16)
  ) u_bit_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .bt(bt)
  );

  // axi4-lite write side: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire logic do_write = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_ctrl = do_write && (aw_addr == MME_OFF_CTRL);
  wire logic wr_vec = do_write && (aw_addr == MME_OFF_RST_VEC);
  wire logic wr_slo = do_write && (aw_addr == MME_OFF_SEC_LO);
  wire logic wr_shi = do_write && (aw_addr == MME_OFF_SEC_HI);
  wire logic wr_baud = do_write && (aw_addr == MME_OFF_BAUD);
  wire logic wr_hit = wr_ctrl || wr_vec || wr_slo || wr_shi || wr_baud;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire logic [31:0] next_vec = merge({16'h0000, rst_vec}, w_data, w_strb);
  wire logic [31:0] next_baud = merge({16'h0000, baud_period}, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      rst_vec <= 16'hFFFF;
      sec_lo <= 32'hFFFFFFFF;
      sec_hi <= 32'hFFFFFFFF;
      baud_period <= MME_BAUD_RESET;
      soft_reenter <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl && w_strb[0]) begin
        soft_reenter <= w_data[0];
      end
      if (wr_vec) begin
        rst_vec <= next_vec[15:0];
      end
      if (wr_slo) begin
        sec_lo <= merge(sec_lo, w_data, w_strb);
      end
      if (wr_shi) begin
        sec_hi <= merge(sec_hi, w_data, w_strb);
      end
      // a zero or one period would stall the bit timer, keep the old one
      if (wr_baud && next_baud[15:1] != 15'h0000) begin
        baud_period <= next_baud[15:0];
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // axi4-lite read side
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      MME_OFF_CTRL: rd_mux = {31'h00000000, soft_reenter};
      MME_OFF_STATUS: rd_mux = {22'h000000, state, watchdog_disable,
        monitor_ready, security_ok, 1'b0, div4_latched, mode};
      MME_OFF_RST_VEC: rd_mux = {16'h0000, rst_vec};
      MME_OFF_SEC_LO: rd_mux = sec_lo;
      MME_OFF_SEC_HI: rd_mux = sec_hi;
      MME_OFF_BAUD: rd_mux = {16'h0000, baud_period};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
endmodule : mme_entry

// File: dv/mme_host_model.sv
// host side model: pulled-up comm line and received security byte strobes
// assumes send is called just after a rising edge
`timescale 1ns/1ps
module mme_host_model (
  // clock
  input wire logic aclk,
  // device drive of the comm pin
  input wire logic dev_oe,
  input wire logic dev_out,
  // line and bytes
  output logic line,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output int low_cnt
);
  // pull-up wins unless someone pulls low
  assign line = !(dev_oe && !dev_out);
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'hA5;
    low_cnt = 0;
  end
  always @(posedge aclk) begin
    if (!line) low_cnt <= low_cnt + 1;
  end
  // one strobe per byte; gap of at least one idle cycle models a slow host
  task send(input logic [7:0] b, input int gap);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    // stale byte is inverted so nothing can match by accident
    rx_byte <= ~b;
    repeat (gap) @(posedge aclk);
  endtask : send
endmodule : mme_host_model

// File: dv/mme_entry_assertions.sv
// checker on the entry control top ports
// assumes one clock and a break of BREAK_CYC cycles
`timescale 1ns/1ps
module mme_entry_assertions
  import mme_pkg::*;
#(
  parameter int BREAK_CYC = 40
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic irq_high_voltage,
  input wire logic reset_pin_high_voltage,
  input wire logic monitor_comm_pin_out,
  input wire logic monitor_comm_pin_oe,
  // status
  input wire logic [1:0] bus_divider,
  input wire logic osc_bypass_div2,
  input wire logic synth_enable,
  input wire logic watchdog_disable,
  input wire logic monitor_active,
  input wire logic extra_reset,
  input wire logic monitor_ready,
  input wire logic [15:0] reset_vector_addr,
  input wire logic [15:0] swi_vector_addr,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  int oe_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) oe_cnt <= 0;
    else oe_cnt <= monitor_comm_pin_oe ? oe_cnt + 1 : 0;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_hv_held;
    (monitor_active && (irq_high_voltage || reset_pin_high_voltage))[*2];
  endsequence
  sequence s_break_end;
    $fell(monitor_comm_pin_oe);
  endsequence
  property p_comm_low; monitor_comm_pin_oe |-> !monitor_comm_pin_out; endproperty
  a_comm_low: assert property (p_comm_low) else $error("comm pin driven high");
  property p_synth_off; monitor_active |-> !synth_enable; endproperty
  a_synth_off: assert property (p_synth_off) else $error("synth on in monitor");
  property p_vec_mon;
    monitor_active |-> reset_vector_addr == MME_VEC_RST_MON && swi_vector_addr == MME_VEC_SWI_MON;
  endproperty
  a_vec_mon: assert property (p_vec_mon) else $error("vectors not moved");
  property p_div2; bus_divider == MME_DIV_BY2 |-> osc_bypass_div2; endproperty
  a_div2: assert property (p_div2) else $error("div2 without bypass");
  property p_div4; bus_divider == MME_DIV_BY4 |-> !osc_bypass_div2; endproperty
  a_div4: assert property (p_div4) else $error("div4 with bypass");
  property p_wd_hv; s_hv_held |-> watchdog_disable; endproperty
  a_wd_hv: assert property (p_wd_hv) else $error("watchdog on under test voltage");
  property p_mode_hold; monitor_active [*2] |-> $stable(bus_divider); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("divider moved after latch");
  property p_xr_pulse; $rose(extra_reset) |=> !extra_reset; endproperty
  a_xr_pulse: assert property (p_xr_pulse) else $error("extra reset too long");
  property p_break_len; s_break_end |-> oe_cnt == BREAK_CYC; endproperty
  a_break_len: assert property (p_break_len) else $error("break length wrong");
  property p_ready; s_break_end |-> ##[0:2] monitor_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing after break");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during response");
endmodule : mme_entry_assertions

// File: dv/tb_mme_entry.sv
// testbench for the entry control: pin scenarios, bus access, security wait
// assumes 40 MHz aclk and a shortened baud period of 4
`timescale 1ns/1ps
module tb_mme_entry;
  import mme_pkg::*;
  logic aclk, aresetn, por_event, reset_pin, reset_pin_high_voltage, irq_high_voltage;
  logic serial_select_pin, mode_select_pin_0, mode_select_pin_1, divider_select_pin;
  logic rx_byte_valid, monitor_comm_pin_in, monitor_comm_pin_out, monitor_comm_pin_oe;
  logic osc_bypass_div2, synth_enable, watchdog_disable, monitor_active, extra_reset;
  logic security_ok, monitor_ready, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, xr_seen;
  logic [7:0] rx_byte, s_axi_awaddr, s_axi_araddr;
  logic [1:0] bus_divider, s_axi_bresp, s_axi_rresp, rr, br;
  logic [15:0] reset_vector_addr, swi_vector_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  int errors, checks, low_cnt, n0;
  mme_entry dut (.aclk, .aresetn, .por_event, .reset_pin, .reset_pin_high_voltage,
    .irq_high_voltage, .monitor_comm_pin_in, .serial_select_pin, .mode_select_pin_0,
    .mode_select_pin_1, .divider_select_pin, .rx_byte_valid, .rx_byte, .monitor_comm_pin_out,
    .monitor_comm_pin_oe, .bus_divider, .osc_bypass_div2, .synth_enable, .watchdog_disable,
    .monitor_active, .extra_reset, .security_ok, .monitor_ready, .reset_vector_addr,
    .swi_vector_addr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  mme_host_model host (.aclk, .dev_oe(monitor_comm_pin_oe), .dev_out(monitor_comm_pin_out),
    .line(monitor_comm_pin_in), .rx_byte_valid, .rx_byte, .low_cnt);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (extra_reset) xr_seen <= 1'b1;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // comm stays released (pulled high) and serial select low throughout
  task enter(input logic irq, input logic div, input logic por, input logic [31:0] vec);
    aresetn <= 1'b0;
    reset_pin <= 1'b0;
    xr_seen <= 1'b0;
    irq_high_voltage <= irq;
    divider_select_pin <= div;
    reset_pin_high_voltage <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(MME_OFF_BAUD, 32'h4);
    wr(MME_OFF_RST_VEC, vec);
    por_event <= por;
    @(posedge aclk);
    por_event <= 1'b0;
    @(posedge aclk);
    reset_pin <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : enter
  // eight bytes with growing gaps, then a bounded wait for the break to finish
  task sec(input logic [63:0] b);
    n0 = low_cnt;
    for (int k = 0; k < 8; k++) host.send(b[8*k+:8], k + 1);
    for (int i = 0; i < 300 && monitor_ready !== 1'b1; i++) @(posedge aclk);
    chk(monitor_ready, 1);
    chk(low_cnt - n0, 40);
  endtask : sec
  task finish_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    finish_test;
  end
  initial begin
    {aresetn, por_event, reset_pin, reset_pin_high_voltage, irq_high_voltage} = '0;
    {serial_select_pin, mode_select_pin_1, divider_select_pin, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, xr_seen} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    mode_select_pin_0 = 1'b1;
    s_axi_wstrb = 4'hF;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(MME_OFF_RST_VEC, rv, rr);
    chk(rv, 32'hFFFF);
    rd(MME_OFF_SEC_HI, rv, rr);
    chk(rv, 32'hFFFFFFFF);
    rd(MME_OFF_BAUD, rv, rr);
    chk(rv, {16'h0, MME_BAUD_RESET});
    rd(8'h3C, rv, rr);
    chk(rr, 2'h2);
    chk(rv, 32'h0);
    wr(8'h3C, 32'h0);
    chk(br, 2'h2);
    $display("registers done");
    enter(1'b1, 1'b0, 1'b1, 32'h1234);
    chk(monitor_active, 1);
    chk(bus_divider, MME_DIV_BY2);
    chk(osc_bypass_div2, 1);
    chk(synth_enable, 0);
    chk(watchdog_disable, 1);
    chk(reset_vector_addr, MME_VEC_RST_MON);
    chk(swi_vector_addr, MME_VEC_SWI_MON);
    divider_select_pin <= 1'b1;
    mode_select_pin_0 <= 1'b0;
    reset_pin_high_voltage <= 1'b1;
    repeat (3) @(posedge aclk);
    irq_high_voltage <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(bus_divider, MME_DIV_BY2);
    chk(watchdog_disable, 1);
    reset_pin_high_voltage <= 1'b0;
    mode_select_pin_0 <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(watchdog_disable, 0);
    wr(MME_OFF_SEC_LO, 32'h44332211);
    wr(MME_OFF_SEC_HI, 32'h88776655);
    sec(64'h8877665544332211);
    chk(security_ok, 1);
    // status: ready state, ready and match set, watchdog back on, normal mode
    rd(MME_OFF_STATUS, rv, rr);
    chk(rv, 32'h00000231);
    $display("normal div2 done");
    enter(1'b1, 1'b1, 1'b1, 32'hFFFF);
    chk(bus_divider, MME_DIV_BY4);
    chk(osc_bypass_div2, 0);
    sec(64'h0);
    chk(security_ok, 0);
    $display("normal div4 done");
    enter(1'b0, 1'b0, 1'b1, 32'hFFFF);
    chk(monitor_active, 1);
    chk(bus_divider, MME_DIV_BY4);
    chk(xr_seen, 1);
    chk(watchdog_disable, 1);
    chk(reset_vector_addr, MME_VEC_RST_MON);
    sec(64'hFFFFFFFFFFFFFFFF);
    chk(security_ok, 1);
    $display("forced done");
    enter(1'b0, 1'b0, 1'b1, 32'h1234);
    chk(monitor_active, 0);
    chk(reset_vector_addr, MME_VEC_RST_USER);
    chk(swi_vector_addr, MME_VEC_SWI_USER);
    chk(watchdog_disable, 0);
    chk(xr_seen, 0);
    $display("user done");
    enter(1'b1, 1'b0, 1'b0, 32'hFFFF);
    chk(monitor_active, 0);
    // re-entry enable lets a plain reset pin pulse latch the pin mode
    wr(MME_OFF_CTRL, 32'h1);
    chk(br, 2'h0);
    reset_pin <= 1'b0;
    @(posedge aclk);
    reset_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(monitor_active, 1);
    $display("no power-on done");
    finish_test;
  end
endmodule : tb_mme_entry
bind mme_entry mme_entry_assertions #(.BREAK_CYC(40)) u_chk (.aclk, .aresetn,
  .irq_high_voltage, .reset_pin_high_voltage, .monitor_comm_pin_out, .monitor_comm_pin_oe,
  .bus_divider, .osc_bypass_div2, .synth_enable, .watchdog_disable, .monitor_active,
  .extra_reset, .monitor_ready, .reset_vector_addr, .swi_vector_addr, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);
